// *** dv/wcr_host_model.sv ***
// Host side model: steps the read burst with random stall cycles
`timescale 1ns/1ps
`default_nettype none
module wcr_host_model (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic run,
  output logic      byte_advance
);
  logic [31:0] rnd_r;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rnd_r        <= 32'h1357_9bdf;
      byte_advance <= 1'b0;
    end else begin
      rnd_r        <= {rnd_r[30:0], rnd_r[31] ^ rnd_r[21] ^ rnd_r[1] ^ rnd_r[0]};
      // Roughly one stall in four, so the far side is not always prompt
      byte_advance <= run & (rnd_r[0] | rnd_r[3]);
    end
  end
endmodule
`default_nettype wire

// *** dv/wrap_order_and_crc_registers_bench.sv ***
// Self-checking bench for the wrap order and CRC register bank
`timescale 1ns/1ps
`default_nettype none
module wrap_order_and_crc_registers_bench;
  import wcr_pkg::*;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic        ic_done, ac_done, check_en, bstart, run, adv;
  logic [7:0]  paddr;
  logic [4:0]  cfg;
  logic [31:0] pwdata, prdata, rd, seed, sa, v, k, ic_val, ac_val, bs_addr, baddr;
  int          n_errors, total_checks, cyc;

  wcr_regs i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .iface_crc_done(ic_done), .iface_crc_value(ic_val),
    .array_crc_done(ac_done), .array_crc_value(ac_val), .iface_check_en(check_en),
    .burst_start(bstart), .burst_start_addr(bs_addr), .byte_advance(adv),
    .byte_addr(baddr));
  wcr_host_model i_host (.pclk(pclk), .presetn(presetn), .run(run), .byte_advance(adv));

  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  function automatic logic [31:0] wexp(input logic [31:0] s, n, input logic [4:0] c);
    logic [31:0] m;
    m = (32'h0000_0008 << c[1:0]) - 32'h0000_0001;
    return c[4] ? ((s & ~m) | ((s + n) & m)) : s + n;
  endfunction
  task automatic rnd;
    repeat (9) seed = lfsr(seed);
  endtask
  task automatic complete_run;
    $display("checks %0d mismatches %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, exp);
    total_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Leaves the bus held so a setup may follow at once; rel frees it
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd  = prdata;
    err = pslverr;
  endtask
  task automatic rel;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      n_errors++;
      complete_run;
    end
  end

  initial begin
    {psel, penable, pwrite, ic_done, ac_done, bstart, run, presetn} = '0;
    {paddr, pwdata, ic_val, ac_val, bs_addr} = '0;
    seed = 32'hdb5e_6fd7;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, OFS_ICE, 0);
    chk(rd, 32'(ICE_RESET));
    apb(1'b0, OFS_ICR, 0);
    chk(rd, ICR_RESET);
    apb(1'b0, OFS_DCR, 0);
    chk(rd, DCR_RESET);
    rel;
    chk(32'(check_en), 32'h0000_0001);
    apb(1'b1, OFS_ICE, 32'hFFFF_FF01);
    apb(1'b0, OFS_ICE, 0);
    chk(rd, 32'h0000_0001);
    apb(1'b1, 8'h20, 0);
    chk(32'(err), 32'h0000_0001);
    rel;
    chk(32'(check_en), 32'h0000_0000);
    apb(1'b1, OFS_ICE, 32'hFFFF_FF00);
    apb(1'b0, OFS_ICE, 0);
    chk(rd, 32'h0000_0000);
    rel;
    chk(32'(check_en), 32'h0000_0001);
    $display("register reset and enable test ends");
    for (int i = 0; i < 4; i++) begin
      rnd;
      v = seed;
      {ic_done, ac_done} <= 2'b11;
      ic_val <= v;
      ac_val <= ~v;
      @(posedge pclk);
      rnd;
      {ic_done, ac_done} <= 2'b00;
      ic_val <= seed;
      ac_val <= seed;
      apb(1'b1, OFS_ICR, seed);
      apb(1'b1, OFS_DCR, ~seed);
      apb(1'b0, OFS_ICR, 0);
      chk(rd, v);
      apb(1'b0, OFS_DCR, 0);
      chk(rd, ~v);
      rel;
    end
    $display("result register test ends");
    for (int m = 0; m < 10; m++) begin
      rnd;
      cfg = (m < 8) ? {3'b100, 2'(m / 2)} : 5'h00;
      // Odd runs start on the last byte of every group size
      sa = m[0] ? (seed | 32'h0000_003F) : seed;
      apb(1'b1, OFS_WRAP_V, 32'(cfg));
      // Nonvolatile copy gets a different value; the burst must not see it
      apb(1'b1, OFS_WRAP_N, 32'(cfg ^ 5'h13));
      apb(1'b0, OFS_WRAP_V, 0);
      chk(rd, 32'(cfg));
      apb(1'b0, OFS_WRAP_N, 0);
      chk(rd, 32'(cfg ^ 5'h13));
      rel;
      bstart  <= 1'b1;
      bs_addr <= sa;
      @(posedge pclk);
      bstart <= 1'b0;
      run    <= 1'b1;
      k = 0;
      repeat (90) begin
        @(negedge pclk);
        chk(baddr, wexp(sa, k, cfg));
        if (adv === 1'b1) k++;
      end
      @(posedge pclk);
      run <= 1'b0;
    end
    $display("burst order test ends");
    complete_run;
  end
endmodule
`default_nettype wire

// *** logic/wcr_addr_gen.sv ***
// Read burst byte address generator, sequential or wrapped
`timescale 1ns/1ps
`default_nettype none
module wcr_addr_gen
  import wcr_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        burst_start,
  input  wire logic [31:0] start_addr,
  input  wire logic        byte_advance,
  input  wire logic        wrap_en,
  input  wire logic [1:0]  wrap_len,
  output logic      [31:0] byte_addr
);
  logic [31:0] byte_addr_r;
  logic        wrap_r;
  logic [1:0]  len_r;
  wire  [31:0] mask_w     = wcr_group_mask(len_r);
  wire  [31:0] inc_w      = byte_addr_r + 32'h0000_0001;
  wire  [31:0] wrapped_w  = (byte_addr_r & ~mask_w) | (inc_w & mask_w);
  wire  [31:0] addr_nxt   = wrap_r ? wrapped_w : inc_w;

  assign byte_addr = byte_addr_r;

  // Mode is latched at burst start so a config write cannot bend a burst
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      byte_addr_r <= ADDR_RESET;
      wrap_r      <= WRAP_EN_RST;
      len_r       <= WRAP_LEN_RST;
    end else if (burst_start) begin
      byte_addr_r <= start_addr;
      wrap_r      <= wrap_en;
      len_r       <= wrap_len;
    end else if (byte_advance) begin
      byte_addr_r <= addr_nxt;
    end
  end

  wire step_w = presetn && !burst_start && byte_advance;

  a_seq_step: assert property (@(posedge pclk) disable iff (!presetn)
    step_w && !wrap_r |=> byte_addr_r == $past(byte_addr_r) + 32'h0000_0001)
    else $error("sequential step wrong");
  a_wrap8_step: assert property (@(posedge pclk) disable iff (!presetn)
    step_w && wrap_r && len_r == 2'b00 |=>
      byte_addr_r[2:0] == $past(byte_addr_r[2:0]) + 3'd1)
    else $error("8 byte wrap step wrong");
  a_wrap16_step: assert property (@(posedge pclk) disable iff (!presetn)
    step_w && wrap_r && len_r == 2'b01 |=>
      byte_addr_r[3:0] == $past(byte_addr_r[3:0]) + 4'd1)
    else $error("16 byte wrap step wrong");
  a_wrap32_step: assert property (@(posedge pclk) disable iff (!presetn)
    step_w && wrap_r && len_r == 2'b10 |=>
      byte_addr_r[4:0] == $past(byte_addr_r[4:0]) + 5'd1)
    else $error("32 byte wrap step wrong");
  a_wrap64_step: assert property (@(posedge pclk) disable iff (!presetn)
    step_w && wrap_r && len_r == 2'b11 |=>
      byte_addr_r[5:0] == $past(byte_addr_r[5:0]) + 6'd1)
    else $error("64 byte wrap step wrong");
  a_high_bits_kept: assert property (@(posedge pclk) disable iff (!presetn)
    step_w && wrap_r |=>
      (byte_addr_r & ~wcr_group_mask(len_r)) == ($past(byte_addr_r) & ~wcr_group_mask(len_r)))
    else $error("wrap touched high address bits");
endmodule
`default_nettype wire

// *** logic/wcr_pkg.sv ***
// Package: register map, reset values and wrap decode for the wrap/CRC register bank
`default_nettype none
package wcr_pkg;
  localparam logic [7:0]  OFS_ICE      = 8'h00;
  localparam logic [7:0]  OFS_ICR      = 8'h04;
  localparam logic [7:0]  OFS_DCR      = 8'h08;
  localparam logic [7:0]  OFS_WRAP_V   = 8'h0C;
  localparam logic [7:0]  OFS_WRAP_N   = 8'h10;
  localparam int          ICE_SEL_BIT  = 0;
  localparam int          WRAP_EN_BIT  = 4;
  localparam logic [7:0]  ICE_RESET    = 8'h00;
  localparam logic [31:0] ICR_RESET    = 32'h0FFF_FFFF;
  localparam logic [31:0] DCR_RESET    = 32'h0000_0000;
  localparam logic        WRAP_EN_RST  = 1'b0;
  localparam logic [1:0]  WRAP_LEN_RST = 2'b00;
  localparam logic [31:0] ADDR_RESET   = 32'h0000_0000;

  // Low address bits that stay inside the wrap group
  function automatic logic [31:0] wcr_group_mask(input logic [1:0] len);
    unique case (len)
      2'b00: wcr_group_mask = 32'h0000_0007;
      2'b01: wcr_group_mask = 32'h0000_000F;
      2'b10: wcr_group_mask = 32'h0000_001F;
      2'b11: wcr_group_mask = 32'h0000_003F;
    endcase
  endfunction
endpackage
`default_nettype wire

// *** logic/wcr_regs.sv ***
// Wrap order and CRC register bank, APB slave
`timescale 1ns/1ps
`default_nettype none
module wcr_regs
  import wcr_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        iface_crc_done,
  input  wire logic [31:0] iface_crc_value,
  input  wire logic        array_crc_done,
  input  wire logic [31:0] array_crc_value,
  output logic             iface_check_en,
  input  wire logic        burst_start,
  input  wire logic [31:0] burst_start_addr,
  input  wire logic        byte_advance,
  output logic      [31:0] byte_addr
);
  logic        iface_check_select_r;
  logic [31:0] icr_r;
  logic [31:0] dcr_r;
  logic        wrap_en_v_r;
  logic [1:0]  wrap_len_v_r;
  logic        wrap_en_n_r;
  logic [1:0]  wrap_len_n_r;
  logic        boot_r;
  logic [31:0] prdata_r;
  logic        pready_r;
  logic        pslverr_r;
  logic        check_en_r;

  wire setup_w  = psel && !penable;
  wire commit_w = psel && penable && pready_r;
  wire wr_w     = commit_w && pwrite;
  wire hit_ice  = paddr == OFS_ICE;
  wire hit_icr  = paddr == OFS_ICR;
  wire hit_dcr  = paddr == OFS_DCR;
  wire hit_wv   = paddr == OFS_WRAP_V;
  wire hit_wn   = paddr == OFS_WRAP_N;
  wire mapped_w = hit_ice | hit_icr | hit_dcr | hit_wv | hit_wn;

  // Reserved bits read back as zero regardless of what was written
  wire [31:0] ice_rd_w = {31'h0, iface_check_select_r};
  wire [31:0] wv_rd_w  = {27'h0, wrap_en_v_r, 2'b00, wrap_len_v_r};
  wire [31:0] wn_rd_w  = {27'h0, wrap_en_n_r, 2'b00, wrap_len_n_r};
  wire [31:0] rd_mux_w = hit_ice ? ice_rd_w :
                         hit_icr ? icr_r :
                         hit_dcr ? dcr_r :
                         hit_wv  ? wv_rd_w :
                         hit_wn  ? wn_rd_w : 32'h0000_0000;

  assign prdata         = prdata_r;
  assign pready         = pready_r;
  assign pslverr        = pslverr_r;
  assign iface_check_en = check_en_r;

  // Zero wait states: answer is registered at the end of the setup cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r  <= 32'h0000_0000;
    end else begin
      pready_r  <= setup_w;
      pslverr_r <= setup_w && !mapped_w;
      if (setup_w && !pwrite) begin
        prdata_r <= rd_mux_w;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      iface_check_select_r <= ICE_RESET[ICE_SEL_BIT];
      check_en_r           <= !ICE_RESET[ICE_SEL_BIT];
    end else begin
      if (wr_w && hit_ice) begin
        iface_check_select_r <= pwdata[ICE_SEL_BIT];
      end
      check_en_r <= !(wr_w && hit_ice ? pwdata[ICE_SEL_BIT] : iface_check_select_r);
    end
  end

  // No write path to the results; only completion strobes move them
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      icr_r <= ICR_RESET;
      dcr_r <= DCR_RESET;
    end else begin
      if (iface_crc_done) begin
        icr_r <= iface_crc_value;
      end
      if (array_crc_done) begin
        dcr_r <= array_crc_value;
      end
    end
  end

  // Volatile wrap copy is loaded from the nonvolatile copy once after reset.
  // Nonvolatile storage itself is modelled by a flop; no array behind it.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      boot_r       <= 1'b1;
      wrap_en_v_r  <= WRAP_EN_RST;
      wrap_len_v_r <= WRAP_LEN_RST;
      wrap_en_n_r  <= WRAP_EN_RST;
      wrap_len_n_r <= WRAP_LEN_RST;
    end else begin
      boot_r <= 1'b0;
      if (boot_r) begin
        wrap_en_v_r  <= wrap_en_n_r;
        wrap_len_v_r <= wrap_len_n_r;
      end else if (wr_w && hit_wv) begin
        wrap_en_v_r  <= pwdata[WRAP_EN_BIT];
        wrap_len_v_r <= pwdata[1:0];
      end
      if (wr_w && hit_wn) begin
        wrap_en_n_r  <= pwdata[WRAP_EN_BIT];
        wrap_len_n_r <= pwdata[1:0];
      end
    end
  end

  wcr_addr_gen u_addr_gen (
    .pclk         (pclk),
    .presetn      (presetn),
    .burst_start  (burst_start),
    .start_addr   (burst_start_addr),
    .byte_advance (byte_advance),
    .wrap_en      (wrap_en_v_r),
    .wrap_len     (wrap_len_v_r),
    .byte_addr    (byte_addr)
  );

  a_select_drives_en: assert property (@(posedge pclk) disable iff (!presetn)
    wr_w && hit_ice |=> iface_check_en == !$past(pwdata[ICE_SEL_BIT]))
    else $error("check enable does not follow select bit");
  a_rsvd_read_zero: assert property (@(posedge pclk) disable iff (!presetn)
    commit_w && !pwrite && hit_ice |-> prdata[31:1] == 31'h0)
    else $error("reserved enable bits not zero");
  a_icr_loads: assert property (@(posedge pclk) disable iff (!presetn)
    iface_crc_done |=> icr_r == $past(iface_crc_value))
    else $error("interface result not loaded");
  a_icr_reset_val: assert property (@(posedge pclk) disable iff (!presetn)
    boot_r |-> icr_r == ICR_RESET && dcr_r == DCR_RESET)
    else $error("result reset value wrong");
  a_dcr_loads: assert property (@(posedge pclk) disable iff (!presetn)
    array_crc_done |=> dcr_r == $past(array_crc_value))
    else $error("array result not loaded");
  a_results_hold: assert property (@(posedge pclk) disable iff (!presetn)
    !iface_crc_done && !array_crc_done |=> $stable(icr_r) && $stable(dcr_r))
    else $error("result changed without completion");
  a_wrap_boot_copy: assert property (@(posedge pclk) disable iff (!presetn)
    boot_r |=> wrap_en_v_r == $past(wrap_en_n_r) && wrap_len_v_r == $past(wrap_len_n_r))
    else $error("volatile wrap copy not loaded");
  a_len_write: assert property (@(posedge pclk) disable iff (!presetn)
    wr_w && hit_wv && !boot_r |=> wrap_len_v_r == $past(pwdata[1:0]))
    else $error("wrap length write lost");
  a_unmapped_err: assert property (@(posedge pclk) disable iff (!presetn)
    setup_w && !mapped_w |=> pslverr && pready)
    else $error("unmapped address not flagged");
  a_setup_answer: assert property (@(posedge pclk) disable iff (!presetn)
    setup_w |=> pready)
    else $error("no ready after setup");
  a_ready_pulse: assert property (@(posedge pclk) disable iff (!presetn)
    pready |=> !pready)
    else $error("ready held past one cycle");
  a_idle_no_ready: assert property (@(posedge pclk) disable iff (!presetn)
    !psel |=> !pready)
    else $error("ready without select");
  a_err_with_ready: assert property (@(posedge pclk) disable iff (!presetn)
    pslverr |-> pready)
    else $error("error without ready");
  a_unmapped_zero: assert property (@(posedge pclk) disable iff (!presetn)
    setup_w && !mapped_w && !pwrite |=> prdata == 32'h0000_0000)
    else $error("unmapped read not zero");
  a_icr_read: assert property (@(posedge pclk) disable iff (!presetn)
    commit_w && !pwrite && hit_icr |-> prdata == $past(icr_r))
    else $error("interface result read wrong");
  a_dcr_read: assert property (@(posedge pclk) disable iff (!presetn)
    commit_w && !pwrite && hit_dcr |-> prdata == $past(dcr_r))
    else $error("array result read wrong");
  a_writes_ignored: assert property (@(posedge pclk) disable iff (!presetn)
    wr_w && (hit_icr || hit_dcr) && !iface_crc_done && !array_crc_done |=>
      $stable(icr_r) && $stable(dcr_r))
    else $error("result register took a write");
  a_en_matches_sel: assert property (@(posedge pclk) disable iff (!presetn)
    iface_check_en != iface_check_select_r)
    else $error("check enable disagrees with select");
  a_sel_holds: assert property (@(posedge pclk) disable iff (!presetn)
    !(wr_w && hit_ice) |=> $stable(iface_check_select_r))
    else $error("select bit changed without write");
  a_wrap_en_write: assert property (@(posedge pclk) disable iff (!presetn)
    wr_w && hit_wv && !boot_r |=> wrap_en_v_r == $past(pwdata[WRAP_EN_BIT]))
    else $error("wrap enable write lost");
  a_nv_wrap_write: assert property (@(posedge pclk) disable iff (!presetn)
    wr_w && hit_wn |=> wrap_en_n_r == $past(pwdata[WRAP_EN_BIT]) &&
      wrap_len_n_r == $past(pwdata[1:0]))
    else $error("nonvolatile wrap write lost");
  a_wrap_rsvd_zero: assert property (@(posedge pclk) disable iff (!presetn)
    commit_w && !pwrite && (hit_wv || hit_wn) |-> prdata[31:5] == 27'h0 && prdata[3:2] == 2'b00)
    else $error("reserved wrap bits not zero");
endmodule
`default_nettype wire
